//--- shared/host_panel_if.sv
/*
  Pin bundle between the controller device end and the host/board end.
  Assumes the testbench reads the resolved pin levels; an undriven wait pin is pulled high, upper panel pins take the tie level, pin zero the host level.
*/
interface host_panel_if;
  logic readStrobeN;
  logic busStartN;
  logic chipSelectN;
  logic waitAckOut;
  logic waitAckOe;
  logic waitAckLevel;
  logic [3:0] configStrap;
  logic testModeEnable;
  logic inputClockPin;
  logic busClockPin;
  logic [2:0] upperPanelOut;
  logic [2:0] upperPanelOe;
  logic [2:0] upperPanelLevel;
  logic upperPanelTie;
  logic panelPowerControl;
  logic generalIoZeroOut;
  logic generalIoZeroOe;
  logic generalIoZeroExt;
  logic generalIoZeroLevel;

  // The wait pin floats high through its pull-up when the device lets go of it.
  assign waitAckLevel = waitAckOe ? waitAckOut : 1'b1;
  assign upperPanelLevel = (upperPanelOe & upperPanelOut) | (~upperPanelOe & {3{upperPanelTie}});
  assign generalIoZeroLevel = generalIoZeroOe ? generalIoZeroOut : generalIoZeroExt;

  modport device (
    input readStrobeN, busStartN, chipSelectN, configStrap, testModeEnable,
    input inputClockPin, busClockPin, upperPanelLevel, generalIoZeroLevel,
    output waitAckOut, waitAckOe, upperPanelOut, upperPanelOe, panelPowerControl,
    output generalIoZeroOut, generalIoZeroOe
  );

  modport host (
    output readStrobeN, busStartN, chipSelectN, configStrap, testModeEnable,
    output inputClockPin, busClockPin, upperPanelTie, generalIoZeroExt,
    input waitAckLevel
  );
endinterface

//--- shared/host_panel_pkg.sv
/*
  Shared constants, types and decode functions for both ends of the host bus and panel pin map.
  Assumes strap levels are stable while reset is held and that one clock drives both ends.
*/
package host_panel_pkg;

  typedef enum logic [4:0] {
    MODE_RESERVED = 5'b00001,
    MODE_STROBE_ONE = 5'b00010,
    MODE_SIZED_ACK = 5'b00100,
    MODE_GEN_SPLIT = 5'b01000,
    MODE_GEN_SINGLE = 5'b10000
  } bus_mode_t;

  typedef enum logic [3:0] {
    HOST_IDLE = 4'b0001,
    HOST_SETUP = 4'b0010,
    HOST_HOLD = 4'b0100,
    HOST_DONE = 4'b1000
  } host_state_t;

  localparam int STRAP_WIDTH = 4;
  localparam int STRAP_ENDIAN_BIT = 3;
  localparam logic [2:0] STRAP_STROBE_ONE = 3'h3;
  localparam logic [2:0] STRAP_SIZED_ACK = 3'h5;
  localparam logic [2:0] STRAP_GENERIC = 3'h7;
  localparam logic [2:0] STRAP_RESERVED = 3'h0;
  localparam int UPPER_PANEL_WIDTH = 3;
  localparam logic [7:0] CFG_REG_OFFSET = 8'h63;
  localparam int CFG_POWER_SAVE_BIT = 2;
  localparam logic WAIT_IDLE_LEVEL = 1'b1;
  localparam logic [2:0] UPPER_PANEL_RESET = 3'h0;

  function automatic bus_mode_t decodeMode(input logic [2:0] strap, input logic busStartLevel);
    bus_mode_t mode;
    mode = MODE_RESERVED;
    case (strap)
      STRAP_STROBE_ONE: mode = MODE_STROBE_ONE;
      STRAP_SIZED_ACK: mode = MODE_SIZED_ACK;
      STRAP_GENERIC: mode = busStartLevel ? MODE_GEN_SINGLE : MODE_GEN_SPLIT;
      default: mode = MODE_RESERVED;
    endcase
    return mode;
  endfunction

  function automatic logic [2:0] encodeMode(input bus_mode_t mode);
    logic [2:0] strap;
    strap = STRAP_RESERVED;
    case (mode)
      MODE_STROBE_ONE: strap = STRAP_STROBE_ONE;
      MODE_SIZED_ACK: strap = STRAP_SIZED_ACK;
      MODE_GEN_SPLIT: strap = STRAP_GENERIC;
      MODE_GEN_SINGLE: strap = STRAP_GENERIC;
      default: strap = STRAP_RESERVED;
    endcase
    return strap;
  endfunction

endpackage

//--- src/host_panel_device.sv
/*
  Device end: straps pick the host bus mode, the read strobe and wait pins follow it,
  and the upper panel pins, general pin zero and panel power are mapped.
  Assumes pins are synchronous to mclk and at least one mclk edge falls inside reset.
*/
// Operation
// [RULE1] Strobe mode one: host ties read strobe high.
// [RULE2] Sized mode: read strobe gives word/byte size.
// [RULE3] Split generic: read strobe reads low byte.
// [RULE4] Single generic: read strobe reads whole access.
// [RULE5] Strobe mode one: wait pin is transfer acknowledge.
// [RULE6] Sized mode: wait pin acknowledges 16-bit port.
// [RULE7] Generic modes: wait pin stretches host cycle.
// [RULE8] Reset restores defaults, outputs go inactive.
// [RULE9] Upper panel pins: data if 12-bit, else GPIO.
// [RULE10] Unused upper panel pins tied to supply.
// [RULE11] Panel power output high means power on.
// [RULE12] Bus clock source: input clock pin held high.
// [RULE13] Straps tied hard, set mode and byte order.
// [RULE14] Config bit picks GPIO zero or power-save input.
// [RULE15] Test enable input held low always.
// [RULE16] Input clock source: bus clock held low.
// [RULE17] Bus start low split, high single generic.
// [RULE18] Straps sampled during reset, held until next.
module host_panel_device (
  input wire logic mclk,
  input wire logic rst,
  host_panel_if.device bus,
  input wire logic panel12Bit,
  input wire logic powerSaveSelect,
  input wire logic accessReady,
  input wire logic panelPowerOn,
  input wire logic [host_panel_pkg::UPPER_PANEL_WIDTH-1:0] panelDataHigh,
  input wire logic [host_panel_pkg::UPPER_PANEL_WIDTH-1:0] gpioHighOut,
  input wire logic [host_panel_pkg::UPPER_PANEL_WIDTH-1:0] gpioHighOe,
  output logic [host_panel_pkg::UPPER_PANEL_WIDTH-1:0] gpioHighIn,
  input wire logic gpioZeroOut,
  input wire logic gpioZeroOe,
  output logic gpioZeroIn,
  output logic powerSaveRequest,
  output host_panel_pkg::bus_mode_t busMode,
  output logic bigEndian,
  output logic accessActive,
  output logic lowByteRead,
  output logic wholeRead,
  output logic wordAccess
);
  import host_panel_pkg::*;

  bus_mode_t strapMode;
  logic strapEndian;
  logic waitAck;
  logic waitAckOe;
  logic [2:0] upperOut;
  logic [2:0] upperOe;
  logic panelPower;
  logic zeroOut;
  logic zeroOe;

  // Every mode but the reserved one gives the read strobe pin and the wait pin a role of their own; decoding
  // the role once keeps the pin logic below free of mode tests.
  typedef enum logic [4:0] {
    READ_ROLE_NONE = 5'b00001,
    READ_ROLE_TIED = 5'b00010,
    READ_ROLE_SIZE = 5'b00100,
    READ_ROLE_LOW_BYTE = 5'b01000,
    READ_ROLE_WHOLE = 5'b10000
  } read_role_t;

  typedef enum logic [2:0] {
    WAIT_ROLE_NONE = 3'b001,
    WAIT_ROLE_ACK = 3'b010,
    WAIT_ROLE_STRETCH = 3'b100
  } wait_role_t;

  function automatic read_role_t readRoleOf(input bus_mode_t mode);
    read_role_t role;
    role = READ_ROLE_NONE;
    case (mode)
      MODE_STROBE_ONE: role = READ_ROLE_TIED; // [RULE1]
      MODE_SIZED_ACK: role = READ_ROLE_SIZE; // [RULE2]
      MODE_GEN_SPLIT: role = READ_ROLE_LOW_BYTE; // [RULE3]
      MODE_GEN_SINGLE: role = READ_ROLE_WHOLE; // [RULE4]
      default: role = READ_ROLE_NONE;
    endcase
    return role;
  endfunction

  function automatic wait_role_t waitRoleOf(input bus_mode_t mode);
    wait_role_t role;
    role = WAIT_ROLE_NONE;
    case (mode)
      MODE_STROBE_ONE: role = WAIT_ROLE_ACK; // [RULE5]
      MODE_SIZED_ACK: role = WAIT_ROLE_ACK; // [RULE6]
      MODE_GEN_SPLIT: role = WAIT_ROLE_STRETCH; // [RULE7]
      MODE_GEN_SINGLE: role = WAIT_ROLE_STRETCH; // [RULE7]
      default: role = WAIT_ROLE_NONE;
    endcase
    return role;
  endfunction

  // A reserved strap code has no role, so the wait pin never leaves its idle level.
  function automatic logic waitLevelOf(input wait_role_t role, input logic active,
      input logic ready);
    logic level;
    level = WAIT_IDLE_LEVEL;
    case (role)
      WAIT_ROLE_ACK: level = !(active & ready); // [RULE5] [RULE6]
      WAIT_ROLE_STRETCH: level = !(active & !ready); // [RULE7]
      default: level = WAIT_IDLE_LEVEL;
    endcase
    return level;
  endfunction

  read_role_t readRole;
  wait_role_t waitRole;
  assign readRole = readRoleOf(strapMode);
  assign waitRole = waitRoleOf(strapMode);
  wire isStrobeMode = (waitRole == WAIT_ROLE_ACK);
  wire isGeneric = (waitRole == WAIT_ROLE_STRETCH);

  // The straps stand only while reset is held, so they are captured by a clocked load,
  // not by the asynchronous reset, and stay frozen until reset comes back.
  always_ff @(posedge mclk) begin
    if (rst) begin
      strapMode <= decodeMode(bus.configStrap[2:0], bus.busStartN); // [RULE13] [RULE17] [RULE18]
      strapEndian <= bus.configStrap[STRAP_ENDIAN_BIT]; // [RULE13] [RULE18]
    end
  end

  // In strobe modes a cycle needs the address strobe; generic modes tie bus start instead.
  wire cycleActive = !bus.chipSelectN & (isStrobeMode ? !bus.busStartN : isGeneric);

  // Mode one ignores the read strobe entirely, so a floating or tied level has no effect.
  wire readLow = !bus.readStrobeN;
  wire next_lowByteRead = cycleActive & (readRole == READ_ROLE_LOW_BYTE) & readLow; // [RULE3]
  wire next_wholeRead = cycleActive & (readRole == READ_ROLE_WHOLE) & readLow; // [RULE4]
  wire next_wordAccess = cycleActive & (readRole == READ_ROLE_SIZE) & bus.readStrobeN; // [RULE2]

  // Acknowledge modes pull low when done; generic modes pull low while not yet done.
  wire next_waitAck = waitLevelOf(waitRole, cycleActive, accessReady); // [RULE5] [RULE6] [RULE7]
  wire next_waitAckOe = cycleActive;

  wire [2:0] next_upperOut = panel12Bit ? panelDataHigh : gpioHighOut; // [RULE9]
  wire [2:0] next_upperOe = panel12Bit ? 3'h7 : gpioHighOe; // [RULE9]

  // The power-save choice forces the pin to input so an external request is never fought.
  wire next_zeroOe = !powerSaveSelect & gpioZeroOe; // [RULE14]
  // Outside 12-bit mode, input samples read whatever the pin resolves to, including the board tie when unused.
  wire [2:0] next_gpioHighIn = panel12Bit ? 3'h0 : bus.upperPanelLevel; // [RULE10]
  wire next_powerSaveRequest = powerSaveSelect & bus.generalIoZeroLevel; // [RULE14]

  // Pin samples are registered so the core sees clean levels that rest inactive in reset;
  // the price is one extra cycle before an input change is seen.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpioHighIn <= 3'h0; // [RULE8]
      gpioZeroIn <= 1'b0;
      powerSaveRequest <= 1'b0;
    end else begin
      gpioHighIn <= next_gpioHighIn;
      gpioZeroIn <= bus.generalIoZeroLevel;
      powerSaveRequest <= next_powerSaveRequest;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitAck <= WAIT_IDLE_LEVEL; // [RULE8]
      waitAckOe <= 1'b0;
      lowByteRead <= 1'b0;
      wholeRead <= 1'b0;
      wordAccess <= 1'b0;
      accessActive <= 1'b0;
    end else begin
      waitAck <= next_waitAck;
      waitAckOe <= next_waitAckOe;
      lowByteRead <= next_lowByteRead;
      wholeRead <= next_wholeRead;
      wordAccess <= next_wordAccess;
      accessActive <= cycleActive;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      upperOut <= UPPER_PANEL_RESET; // [RULE8]
      upperOe <= 3'h0;
      panelPower <= 1'b0; // [RULE8]
      zeroOut <= 1'b0;
      zeroOe <= 1'b0;
    end else begin
      upperOut <= next_upperOut;
      upperOe <= next_upperOe;
      panelPower <= panelPowerOn; // [RULE11]
      zeroOut <= gpioZeroOut;
      zeroOe <= next_zeroOe;
    end
  end

  assign bus.waitAckOut = waitAck;
  assign bus.waitAckOe = waitAckOe;
  assign bus.upperPanelOut = upperOut;
  assign bus.upperPanelOe = upperOe;
  assign bus.panelPowerControl = panelPower;
  assign bus.generalIoZeroOut = zeroOut;
  assign bus.generalIoZeroOe = zeroOe;

  assign busMode = strapMode;
  assign bigEndian = strapEndian;

endmodule

//--- src/host_panel_host.sv
/*
  Host and board end: drives straps and ties, runs one read cycle per request in the
  selected bus mode, and watches the wait/acknowledge pin to end it.
  Assumes modeSel and the tie choices stay fixed while out of reset.
*/
module host_panel_host (
  input wire logic mclk,
  input wire logic rst,
  host_panel_if.host bus,
  input wire host_panel_pkg::bus_mode_t modeSel,
  input wire logic bigEndianSel,
  input wire logic useBusClock,
  input wire logic upperPinsUnused,
  input wire logic powerSaveIn,
  input wire logic startRead,
  input wire logic wordRead,
  output logic readBusy,
  output logic cycleDone
);
  import host_panel_pkg::*;

  host_state_t state;
  host_state_t next_state;
  logic clockToggle;
  logic sizeWord;

  wire isGeneric = (modeSel == MODE_GEN_SPLIT) | (modeSel == MODE_GEN_SINGLE);
  wire inCycle = (state == HOST_SETUP) | (state == HOST_HOLD);
  // Generic cycles finish when wait is released; acknowledge modes when it is pulled low.
  wire cycleEnds = isGeneric ? bus.waitAckLevel : !bus.waitAckLevel; // [RULE5] [RULE6] [RULE7]

  always_comb begin
    next_state = state;
    case (state)
      HOST_IDLE: next_state = startRead ? HOST_SETUP : HOST_IDLE;
      HOST_SETUP: next_state = HOST_HOLD;
      HOST_HOLD: next_state = cycleEnds ? HOST_DONE : HOST_HOLD;
      HOST_DONE: next_state = HOST_IDLE;
      default: next_state = HOST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= HOST_IDLE;
      clockToggle <= 1'b0;
      sizeWord <= 1'b0;
    end else begin
      state <= next_state;
      clockToggle <= !clockToggle;
      if (state == HOST_IDLE && startRead) begin
        sizeWord <= wordRead;
      end
    end
  end

  assign bus.configStrap = {bigEndianSel, encodeMode(modeSel)}; // [RULE13]
  assign bus.testModeEnable = 1'b0; // [RULE15]
  // The unused clock pin is tied; the chosen one carries a divided copy of mclk.
  assign bus.inputClockPin = useBusClock ? 1'b1 : clockToggle; // [RULE12]
  assign bus.busClockPin = useBusClock ? clockToggle : 1'b0; // [RULE16]
  assign bus.upperPanelTie = upperPinsUnused; // [RULE10]
  assign bus.generalIoZeroExt = powerSaveIn;
  assign bus.chipSelectN = !inCycle;

  always_comb begin
    bus.busStartN = 1'b1;
    bus.readStrobeN = 1'b1;
    case (modeSel)
      MODE_STROBE_ONE: begin
        bus.busStartN = !inCycle;
        bus.readStrobeN = 1'b1; // [RULE1]
      end
      MODE_SIZED_ACK: begin
        bus.busStartN = !inCycle;
        bus.readStrobeN = inCycle & sizeWord; // [RULE2]
      end
      MODE_GEN_SPLIT: begin
        bus.busStartN = 1'b0; // [RULE17]
        bus.readStrobeN = !inCycle; // [RULE3]
      end
      MODE_GEN_SINGLE: begin
        bus.busStartN = 1'b1; // [RULE17]
        bus.readStrobeN = !inCycle; // [RULE4]
      end
      default: begin
        bus.busStartN = 1'b1;
        bus.readStrobeN = 1'b1;
      end
    endcase
  end

  assign readBusy = (state != HOST_IDLE);
  assign cycleDone = (state == HOST_DONE);

endmodule

//--- tb/host_panel_properties.sv
/*
  Pin checks between the device end and the host end of the pin map.
  Assumes one clock, reset active high, and straps changed only inside reset.
*/
module host_panel_properties (
  input wire logic mclk,
  input wire logic rst,
  input wire logic readStrobeN,
  input wire logic busStartN,
  input wire logic chipSelectN,
  input wire logic waitAckOe,
  input wire logic [3:0] configStrap,
  input wire logic [2:0] upperPanelOe,
  input wire logic panelPowerControl,
  input wire logic generalIoZeroOe
);
  timeunit 1ns;
  timeprecision 100ps;
  import host_panel_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  sequence csOpen;
    $fell(chipSelectN);
  endsequence
  sequence csClose;
    $rose(chipSelectN);
  endsequence
  // Checked while reset is high, so this one must not be disabled by it; the first edge
  // in reset is skipped because the outputs may only settle there.
  reset_idle_a: assert property (disable iff (1'h0) $past(rst) && rst |->
    !waitAckOe && !panelPowerControl && upperPanelOe == 3'h0 && !generalIoZeroOe)
    else $error("output active in reset");
  wait_release_a: assert property (chipSelectN |=> !waitAckOe)
    else $error("wait pin held after deselect");
  ack_strobe_a: assert property ((configStrap[2:0] == STRAP_STROBE_ONE) &&
    !chipSelectN && !busStartN |=> waitAckOe) else $error("no acknowledge drive");
  ack_sized_a: assert property ((configStrap[2:0] == STRAP_SIZED_ACK) &&
    !chipSelectN && !busStartN |=> waitAckOe) else $error("no size acknowledge drive");
  wait_generic_a: assert property ((configStrap[2:0] == STRAP_GENERIC) && !chipSelectN
    |=> waitAckOe) else $error("no wait drive");
  strobe_tied_a: assert property ((configStrap[2:0] == STRAP_STROBE_ONE)
    |-> readStrobeN) else $error("read strobe not tied high");
  generic_read_a: assert property ((configStrap[2:0] == STRAP_GENERIC)
    && !chipSelectN |-> !readStrobeN) else $error("read strobe missing");
  strap_hold_a: assert property ($stable(configStrap)) else $error("strap moved");
  start_tie_a: assert property ((configStrap[2:0] == STRAP_GENERIC)
    |-> $stable(busStartN)) else $error("bus start moved");
  cycle_bound_a: assert property (csOpen |-> ##[2:40] csClose)
    else $error("host cycle did not end");
endmodule

//--- tb/testbench.sv
/*
  Bench for both ends joined by the pin interface; runs reads in all four modes.
  Assumes the host end drives the general pin zero level from powerSaveIn.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import host_panel_pkg::*;
  logic mclk, rst, panel12Bit, powerSaveSelect, accessReady, panelPowerOn;
  logic [2:0] panelDataHigh, gpioHighOut, gpioHighOe, gpioHighIn;
  logic gpioZeroOut, gpioZeroOe, gpioZeroIn, powerSaveRequest, bigEndian, powerSaveIn;
  logic accessActive, lowByteRead, wholeRead, wordAccess;
  logic bigEndianSel, useBusClock, startRead, wordRead, readBusy, cycleDone, upperPinsUnused;
  bus_mode_t busMode, modeSel;
  int bad_count = 0;
  int checks = 0;
  int cycles = 0;
  bus_mode_t modes [4] = '{MODE_STROBE_ONE, MODE_SIZED_ACK, MODE_GEN_SPLIT, MODE_GEN_SINGLE};
  host_panel_if hpIf();
  host_panel_device u_host_panel_device (.mclk(mclk), .rst(rst), .bus(hpIf),
    .panel12Bit(panel12Bit), .powerSaveSelect(powerSaveSelect), .accessReady(accessReady),
    .panelPowerOn(panelPowerOn), .panelDataHigh(panelDataHigh), .gpioHighOut(gpioHighOut),
    .gpioHighOe(gpioHighOe), .gpioHighIn(gpioHighIn), .gpioZeroOut(gpioZeroOut),
    .gpioZeroOe(gpioZeroOe), .gpioZeroIn(gpioZeroIn), .powerSaveRequest(powerSaveRequest),
    .busMode(busMode), .bigEndian(bigEndian), .accessActive(accessActive),
    .lowByteRead(lowByteRead), .wholeRead(wholeRead), .wordAccess(wordAccess));
  host_panel_host u_host_panel_host (.mclk(mclk), .rst(rst), .bus(hpIf), .modeSel(modeSel),
    .bigEndianSel(bigEndianSel), .useBusClock(useBusClock), .upperPinsUnused(upperPinsUnused),
    .powerSaveIn(powerSaveIn), .startRead(startRead), .wordRead(wordRead),
    .readBusy(readBusy), .cycleDone(cycleDone));
  host_panel_properties u_host_panel_properties (.mclk(mclk), .rst(rst),
    .readStrobeN(hpIf.readStrobeN), .busStartN(hpIf.busStartN),
    .chipSelectN(hpIf.chipSelectN), .waitAckOe(hpIf.waitAckOe),
    .configStrap(hpIf.configStrap), .upperPanelOe(hpIf.upperPanelOe),
    .panelPowerControl(hpIf.panelPowerControl), .generalIoZeroOe(hpIf.generalIoZeroOe));

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input string what, input logic [4:0] exp, input logic [4:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Power is requested through reset so a leak of the request shows on the pin.
  task automatic do_reset(input bus_mode_t m);
    rst = 1'h1;
    modeSel = m;
    panelPowerOn = 1'h1;
    repeat (20) @(negedge mclk);
    check("power in reset", 1'h0, hpIf.panelPowerControl);
    check("wait in reset", 1'h1, hpIf.waitAckLevel);
    rst = 1'h0;
    panelPowerOn = 1'h0;
    @(negedge mclk);
  endtask

  task automatic do_read(input logic word, input int i);
    int n;
    wordRead = word;
    accessReady = 1'h0;
    startRead = 1'h1;
    @(negedge mclk);
    startRead = 1'h0;
    repeat (5) @(negedge mclk);
    check("busy", 1'h1, readBusy);
    check("wait pin", i < 2, hpIf.waitAckLevel);
    accessReady = 1'h1;
    n = 0;
    while (cycleDone !== 1'h1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    check("done", 1'h1, cycleDone);
    check("active", 1'h1, accessActive);
    check("low byte", i == 2, lowByteRead);
    check("whole", i == 3, wholeRead);
    if (i == 1) check("word", word, wordAccess);
    @(negedge mclk);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    rst = 1'h1;
    {panel12Bit, powerSaveSelect, accessReady, panelPowerOn, startRead, wordRead} = 6'h0;
    {gpioZeroOut, gpioZeroOe, powerSaveIn, bigEndianSel, useBusClock} = 5'h0;
    {panelDataHigh, gpioHighOut, gpioHighOe} = 9'h0;
    upperPinsUnused = 1'h1;
    modeSel = MODE_STROBE_ONE;
    for (int i = 0; i < 4; i++) begin
      bigEndianSel = i[0];
      useBusClock = i[1];
      do_reset(modes[i]);
      check("mode", modes[i], busMode);
      check("endian", bigEndianSel, bigEndian);
      check("test enable", 1'h0, hpIf.testModeEnable);
      if (useBusClock) begin
        check("clock pin tie", 1'h1, hpIf.inputClockPin);
      end else begin
        check("bus clock tie", 1'h0, hpIf.busClockPin);
      end
      for (int w = 0; w < 2; w++) do_read(w[0], i);
      $display("mode test %0d finished", i);
    end
    // A reserved strap code must leave the wait pin alone; the stuck host is freed by reset.
    do_reset(MODE_RESERVED);
    check("mode", MODE_RESERVED, busMode);
    startRead = 1'h1;
    @(negedge mclk);
    startRead = 1'h0;
    repeat (5) @(negedge mclk);
    check("reserved busy", 1'h1, readBusy);
    check("reserved active", 1'h0, accessActive);
    check("reserved wait", 1'h1, hpIf.waitAckLevel);
    do_reset(MODE_STROBE_ONE);
    $display("reserved test finished");
    panel12Bit = 1'h1;
    panelDataHigh = 3'h5;
    gpioHighOe = 3'h3;
    gpioHighOut = 3'h2;
    panelPowerOn = 1'h1;
    repeat (2) @(negedge mclk);
    check("panel data", 3'h5, hpIf.upperPanelLevel);
    check("gpio masked", 3'h0, gpioHighIn);
    check("power on", 1'h1, hpIf.panelPowerControl);
    panel12Bit = 1'h0;
    panelPowerOn = 1'h0;
    repeat (2) @(negedge mclk);
    check("gpio pins", 3'h6, hpIf.upperPanelLevel);
    check("gpio in", 3'h6, gpioHighIn);
    check("power off", 1'h0, hpIf.panelPowerControl);
    gpioHighOe = 3'h0;
    repeat (2) @(negedge mclk);
    check("tied pins", 3'h7, gpioHighIn);
    $display("panel test finished");
    {powerSaveSelect, powerSaveIn, gpioZeroOe} = 3'h7;
    repeat (2) @(negedge mclk);
    check("pin zero drive", 1'h0, hpIf.generalIoZeroOe);
    check("save request", 1'h1, powerSaveRequest);
    powerSaveSelect = 1'h0;
    repeat (2) @(negedge mclk);
    check("pin zero drive", 1'h1, hpIf.generalIoZeroOe);
    check("pin zero in", 1'h0, gpioZeroIn);
    check("save request", 1'h0, powerSaveRequest);
    $display("pin zero test finished");
    print_verdict();
  end
endmodule
